// ===== verilog/hpb_decode_cfg.v
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`include "hpb_consts.vh"

module hpb_decode_cfg (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Avalon-MM slave, word addressed by register index
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // PCI master burst control
    input wire pci_clk_en,
    input wire burst_active,
    input wire bridge_grant_in_n,
    output reg burst_stop,
    // Host memory decode
    input wire host_mem_valid,
    input wire [35:0] host_mem_addr,
    input wire host_gap_hit,
    output reg host_mem_claim,
    // PCI memory towards host
    input wire pci_mem_valid,
    input wire [35:0] pci_mem_addr,
    input wire pci_gap_hit,
    output reg pci_mem_to_host,
    // PCI I/O towards host
    input wire pci_io_valid,
    input wire [31:0] pci_io_addr,
    output reg pci_io_to_host,
    // Host I/O towards PCI
    input wire host_io_valid,
    input wire [31:0] host_io_addr,
    output reg [31:0] pci_io_ad,
    output reg [15:4] io_cmp_addr,
    output reg io_cmp_valid,
    output reg io_alias_hit
);

// ==========================================
// Helpers

// Address at or above programmed top, in 1 Mbyte units
function above_top;
    input [15:0] addr_mb;
    input [15:0] top_mb;
    begin
        above_top = (addr_mb >= top_mb);
    end
endfunction

// Byte-lane merge of a write into a register word
// Lanes without their enable keep the old bits, so a narrow write
// cannot disturb its neighbours.
function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer i;
    begin
        lane_merge = old_val;
        for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
                lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
    end
endfunction

// ISA expansion alias: any nonzero A[9:8] with aliasing switched on
function is_alias;
    input [15:0] addr;
    input en;
    begin
        is_alias = en & (addr[9:8] != 2'b00);
    end
endfunction

// ==========================================
// Registers
// Latency limit in PCI clocks
reg [7:0] latency_r;
// Top of memory: enable at 31, limit at 15:0, the rest held at zero
reg [31:0] top_mem_r;
// Decode mode: only bits 2:1 are live
reg [7:0] decode_r;
// Running latency count of the current burst
reg [7:0] lat_cnt_r;

// Field taps
wire tom_en = top_mem_r[`HPB_TOM_EN_BIT];
wire [15:0] tom_mb = top_mem_r[`HPB_TOM_ADDR_HI:0];
wire io_mask_en = decode_r[`HPB_DEC_MASK_BIT];
wire alias_en = decode_r[`HPB_DEC_ALIAS_BIT];

// ==========================================
// Read-back views
// Reserved bits are wired to zero rather than stored, so no write can
// make them read back anything else.
// Header and self-test are constants; writes to them go nowhere.
wire [31:0] latency_view = {24'h00_0000, latency_r};
wire [31:0] header_view = {24'h00_0000, `HPB_HEADER_VAL};
wire [31:0] selftest_view = {24'h00_0000, `HPB_SELFTEST_VAL};
wire [31:0] top_mem_view = {top_mem_r[31], 15'h0000, top_mem_r[15:0]};
wire [31:0] decode_view = {24'h00_0000, 5'h00, decode_r[2:1], 1'b0};

// ==========================================
// Bus slave
// Accept on an edge where a request meets waitrequest high, then drop
// waitrequest for one cycle. Read data loads at the accepting edge; a
// write commits at the next edge, where the master sees waitrequest low
// and still holds address and data.
wire bus_req = (avs_read | avs_write) & avs_waitrequest;

reg [31:0] rd_word;
reg [31:0] wr_merge;

always @* begin
    wr_merge = lane_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    case (avs_address)
        `HPB_IDX_LATENCY: begin
            rd_word = latency_view;
        end

        `HPB_IDX_HEADER: begin
            rd_word = header_view;
        end

        `HPB_IDX_SELFTEST: begin
            rd_word = selftest_view;
        end

        `HPB_IDX_TOP_MEM: begin
            rd_word = top_mem_view;
        end

        `HPB_IDX_DECODE: begin
            rd_word = decode_view;
        end
        default: begin
            rd_word = 32'h0000_0000;
        end
    endcase
end

// ==========================================
// Register next values
// A write commits only on the edge where the master still holds the
// request and sees waitrequest low, one cycle after it was accepted.
wire wr_commit = avs_write & ~avs_waitrequest;

reg [7:0] latency_nxt;
reg [31:0] top_mem_nxt;
reg [7:0] decode_nxt;

always @* begin
    latency_nxt = latency_r;
    top_mem_nxt = top_mem_r;
    decode_nxt = decode_r;

    if (wr_commit) begin
        case (avs_address)
            `HPB_IDX_LATENCY: begin
                // Narrow registers take byte lane 0 only
                if (avs_byteenable[0]) begin
                    latency_nxt = wr_merge[7:0];
                end
            end

            `HPB_IDX_TOP_MEM: begin
                top_mem_nxt = lane_merge(top_mem_r, avs_writedata, avs_byteenable);
                // Reserved bits held at zero even if software misbehaves
                top_mem_nxt[30:16] = 15'h0000;
            end

            `HPB_IDX_DECODE: begin
                if (avs_byteenable[0]) begin
                    decode_nxt = {5'h00, wr_merge[2:1], 1'b0};
                end
            end

            // Header, self-test and unmapped words drop writes
            default: begin
                decode_nxt = decode_r;
            end
        endcase
    end
end

// Handshake next values: accept when idle, answer one cycle later
// Waitrequest idles high, so no request can slip through unanswered
reg wait_nxt;
reg [31:0] readdata_nxt;

always @* begin
    wait_nxt = 1'b1;
    readdata_nxt = avs_readdata;
    if (bus_req) begin
        wait_nxt = 1'b0;
        // Read data stands until the next accepted request
        readdata_nxt = avs_read ? rd_word : 32'h0000_0000;
    end
end

always @(posedge mclk) begin
    if (rst) begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h0000_0000;
        latency_r <= `HPB_LATENCY_RST;
        top_mem_r <= `HPB_TOP_MEM_RST;
        decode_r <= `HPB_DECODE_RST;
    end else begin
        avs_waitrequest <= wait_nxt;
        avs_readdata <= readdata_nxt;
        latency_r <= latency_nxt;
        top_mem_r <= top_mem_nxt;
        decode_r <= decode_nxt;
    end
end

// ==========================================
// Master latency timer
// Counts PCI clocks from burst start; a zero setting stops at once
// when grant is gone. The stop is one mclk late because it is
// registered, which stays well inside one PCI clock.
reg [7:0] lat_cnt_nxt;
reg burst_stop_nxt;

always @* begin
    lat_cnt_nxt = lat_cnt_r;
    if (!burst_active) begin
        // Idle between bursts: reload the programmed limit
        lat_cnt_nxt = latency_r;
    end else if (pci_clk_en && lat_cnt_r != 8'h00) begin
        lat_cnt_nxt = lat_cnt_r - 8'h01;
    end
end

always @* begin
    burst_stop_nxt = 1'b0;
    if (burst_active && bridge_grant_in_n) begin
        // Grant lost: end the burst once the limit has run out
        burst_stop_nxt = (lat_cnt_r == 8'h00);
    end
end

always @(posedge mclk) begin
    if (rst) begin
        lat_cnt_r <= `HPB_LATENCY_RST;
        burst_stop <= 1'b0;
    end else begin
        lat_cnt_r <= lat_cnt_nxt;
        burst_stop <= burst_stop_nxt;
    end
end

// ==========================================
// Memory decode
// Top of memory is kept in 1 Mbyte units, so only A[35:20] take part.
wire [15:0] host_mb = host_mem_addr[`HPB_HADDR_TOM_HI:`HPB_HADDR_TOM_LO];
wire [15:0] pci_mb = pci_mem_addr[`HPB_HADDR_TOM_HI:`HPB_HADDR_TOM_LO];
wire host_hit = above_top(host_mb, tom_mb);
wire pci_hit = above_top(pci_mb, tom_mb);

// A 36-bit address cannot reach 64 Gbytes, so no upper bound is needed
wire host_fwd = tom_en & host_hit & ~host_gap_hit;
// Gap windows are not forwarded to PCI, so they are not blocked
// towards the host either
wire pci_fwd = tom_en & pci_hit & ~pci_gap_hit;

// Claim is registered: the host side sees it one cycle after the address
always @(posedge mclk) begin
    if (rst) begin
        host_mem_claim <= 1'b0;
        pci_mem_to_host <= 1'b0;
    end else begin
        host_mem_claim <= host_mem_valid & host_fwd;
        // Forwarded range is never passed back onto the host bus
        pci_mem_to_host <= pci_mem_valid & ~pci_fwd;
    end
end

// ==========================================
// I/O decode
// Only the low 64 Kbytes of a host I/O address are decoded; A16 may
// still be set by a real-mode processor and is dropped here.
wire [15:0] host_io_low = host_io_addr[15:0];
wire host_io_alias = is_alias(host_io_low, alias_en);
reg [15:0] io_dec;

always @* begin
    io_dec = host_io_low;
    // Nonzero A[9:8] is an ISA expansion alias of 100-3FFh
    if (host_io_alias) begin
        io_dec[15:10] = 6'h00;
    end
end

// PCI I/O above 64 Kbytes never reaches the host bus
wire pci_io_low = (pci_io_addr[`HPB_IO_LIMIT_HI:`HPB_IO_LIMIT_LO] == 16'h0000);

// Mask enable clears AD[31:16]; with it off the full host address goes out
wire [31:0] pci_ad_nxt = io_mask_en ? {16'h0000, host_io_low} : host_io_addr;

always @(posedge mclk) begin
    if (rst) begin
        pci_io_to_host <= 1'b0;
        pci_io_ad <= 32'h0000_0000;
        io_cmp_addr <= 12'h000;
        io_cmp_valid <= 1'b0;
        io_alias_hit <= 1'b0;
    end else begin
        pci_io_to_host <= pci_io_valid & pci_io_low;
        pci_io_ad <= pci_ad_nxt;
        // Compare address is presented with its valid in the same cycle
        io_cmp_addr <= io_dec[15:4];
        io_cmp_valid <= host_io_valid;
        io_alias_hit <= host_io_valid & host_io_alias;
    end
end

endmodule // hpb_decode_cfg

// ===== verilog/hpb_consts.vh
`ifndef HPB_CONSTS_VH
`define HPB_CONSTS_VH

// ==========================================
// Register indices (byte address = 4 * index)
`define HPB_IDX_LATENCY 8'h0d
`define HPB_IDX_HEADER 8'h0e
`define HPB_IDX_SELFTEST 8'h0f
`define HPB_IDX_TOP_MEM 8'h40
`define HPB_IDX_DECODE 8'h48

// ==========================================
// Reset and fixed values
`define HPB_LATENCY_RST 8'h20
`define HPB_HEADER_VAL 8'h00
`define HPB_SELFTEST_VAL 8'h00
`define HPB_TOP_MEM_RST 32'h0000_0000
`define HPB_DECODE_RST 8'h06

// ==========================================
// Field positions
`define HPB_TOM_EN_BIT 31
`define HPB_TOM_ADDR_HI 15
`define HPB_DEC_MASK_BIT 2
`define HPB_DEC_ALIAS_BIT 1

// ==========================================
// Address fields
`define HPB_HADDR_TOM_HI 35
`define HPB_HADDR_TOM_LO 20
`define HPB_IO_LIMIT_HI 31
`define HPB_IO_LIMIT_LO 16

`endif

// ===== verification/hpb_pci_far.sv
`timescale 1ns/10ps
// ==========================================
// PCI side: clock enable and arbiter grant
module hpb_pci_far (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Another master asks for the bus
    input wire other_req,
    // Towards the bridge
    output reg pci_clk_en,
    output reg bridge_grant_in_n
);
    reg [1:0] div_r;
    always @(posedge mclk) begin
        if (rst) begin
            div_r <= 2'h0;
            pci_clk_en <= 1'b0;
            bridge_grant_in_n <= 1'b1;
        end else begin
            div_r <= div_r + 2'h1;
            pci_clk_en <= (div_r == 2'h3);
            // Arbiter only moves grant on a PCI clock
            if (pci_clk_en) bridge_grant_in_n <= other_req;
        end
    end
endmodule // hpb_pci_far

// ===== verification/hpb_cfg_checker.sv
`timescale 1ns/10ps
`include "hpb_consts.vh"
// ==========================================
// Port checker
module hpb_cfg_checker (
    // Clock and bus
    input wire mclk,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Decode paths
    input wire burst_active,
    input wire bridge_grant_in_n,
    input wire burst_stop,
    input wire host_mem_valid,
    input wire host_gap_hit,
    input wire host_mem_claim,
    input wire pci_io_valid,
    input wire [31:0] pci_io_addr,
    input wire pci_io_to_host,
    input wire host_io_valid,
    input wire [31:0] host_io_addr,
    input wire [31:0] pci_io_ad,
    input wire [15:4] io_cmp_addr,
    input wire io_alias_hit
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire rd_take = avs_waitrequest && avs_read;
    property p_hdr; rd_take && avs_address == `HPB_IDX_HEADER |=> avs_readdata == 32'h0; endproperty
    a_hdr: assert property (p_hdr) else $error("header type not zero");
    property p_self; rd_take && avs_address == `HPB_IDX_SELFTEST |=> avs_readdata == 32'h0; endproperty
    a_self: assert property (p_self) else $error("self test not zero");
    property p_pio; pci_io_valid && pci_io_addr[31:16] != 16'h0 |=> !pci_io_to_host; endproperty
    a_pio: assert property (p_pio) else $error("high io passed");
    property p_ad; host_io_valid |=> pci_io_ad[15:0] == $past(host_io_addr[15:0]); endproperty
    a_ad: assert property (p_ad) else $error("io low half changed");
    property p_nal; host_io_valid && host_io_addr[9:8] == 2'h0 |=> !io_alias_hit
        && io_cmp_addr == $past(host_io_addr[15:4]); endproperty
    a_nal: assert property (p_nal) else $error("plain io compare wrong");
    property p_al; io_alias_hit |-> io_cmp_addr[15:10] == 6'h0; endproperty
    a_al: assert property (p_al) else $error("alias bits kept");
    property p_stop; burst_stop |-> $past(burst_active && bridge_grant_in_n); endproperty
    a_stop: assert property (p_stop) else $error("stop without grant loss");
    property p_claim; host_mem_claim |-> $past(host_mem_valid && !host_gap_hit); endproperty
    a_claim: assert property (p_claim) else $error("stray claim");
endmodule // hpb_cfg_checker

bind hpb_decode_cfg hpb_cfg_checker i_hpb_cfg_checker (.mclk, .rst, .avs_address, .avs_read,
    .avs_readdata, .avs_waitrequest, .burst_active, .bridge_grant_in_n, .burst_stop,
    .host_mem_valid, .host_gap_hit, .host_mem_claim, .pci_io_valid, .pci_io_addr,
    .pci_io_to_host, .host_io_valid, .host_io_addr, .pci_io_ad, .io_cmp_addr, .io_alias_hit);

// ===== verification/testbench.sv
`timescale 1ns/10ps
// ==========================================
// Bench
module testbench;
    logic mclk = '0, rst = '1, avs_read = '0, avs_write = '0, avs_waitrequest, burst_stop;
    logic pci_clk_en, bridge_grant_in_n, burst_active = '0, other_req = '0, host_mem_valid = '0;
    logic host_gap_hit = '0, host_mem_claim, pci_mem_valid = '0, pci_gap_hit = '0;
    logic pci_mem_to_host, pci_io_valid = '0, pci_io_to_host, host_io_valid = '0;
    logic io_cmp_valid, io_alias_hit;
    logic [7:0] avs_address = '0;
    logic [3:0] avs_byteenable = '1;
    logic [31:0] avs_writedata = '0, avs_readdata, pci_io_addr = '0, host_io_addr = '0;
    logic [31:0] pci_io_ad, q;
    logic [35:0] host_mem_addr = '0, pci_mem_addr = '0;
    logic [15:4] io_cmp_addr;
    integer failures = 0, n_checks = 0, cyc = 0, n;
    hpb_decode_cfg i_hpb_decode_cfg (.mclk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pci_clk_en,
        .burst_active, .bridge_grant_in_n, .burst_stop, .host_mem_valid, .host_mem_addr,
        .host_gap_hit, .host_mem_claim, .pci_mem_valid, .pci_mem_addr, .pci_gap_hit,
        .pci_mem_to_host, .pci_io_valid, .pci_io_addr, .pci_io_to_host, .host_io_valid,
        .host_io_addr, .pci_io_ad, .io_cmp_addr, .io_cmp_valid, .io_alias_hit);
    hpb_pci_far i_hpb_pci_far (.mclk, .rst, .other_req, .pci_clk_en, .bridge_grant_in_n);
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            close_out;
        end
    end
    task close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until waitrequest seen low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readdata", e, q);
    endtask
    task mem(input logic [35:0] a, input logic g, input logic ec, input logic ep);
        {host_mem_valid, pci_mem_valid, host_gap_hit, pci_gap_hit} <= {2'h3, g, g};
        {host_mem_addr, pci_mem_addr} <= {a, a};
        repeat (2) @(posedge mclk);
        chk("claim", ec, host_mem_claim);
        chk("to_host", ep, pci_mem_to_host);
    endtask
    task hio(input logic [31:0] a, input logic [31:0] ead, input logic [15:4] ec, input logic ea);
        host_io_valid <= 1'b1;
        host_io_addr <= a;
        repeat (2) @(posedge mclk);
        chk("io_ad", ead, pci_io_ad);
        chk("io_cmp", ec, io_cmp_addr);
        chk("io_valid", 32'h1, io_cmp_valid);
        chk("io_alias", ea, io_alias_hit);
    endtask
    task t_regs;
        rchk(8'h0d, 32'h0000_0020);
        rchk(8'h48, 32'h0000_0006);
        bus(1'b1, 8'h0e, 32'hffff_ffff);
        bus(1'b1, 8'h0f, 32'hffff_ffff);
        bus(1'b1, 8'h10, 32'hffff_ffff);
        rchk(8'h0e, 32'h0000_0000);
        rchk(8'h0f, 32'h0000_0000);
        rchk(8'h10, 32'h0000_0000);
    endtask
    task t_top;
        bus(1'b1, 8'h40, 32'hffff_ffff);
        rchk(8'h40, 32'h8000_ffff);
        bus(1'b1, 8'h40, 32'h8000_0010);
        mem(36'h0_0100_0000, 1'b0, 1'b1, 1'b0);
        mem(36'h0_00f0_0000, 1'b0, 1'b0, 1'b1);
        mem(36'hf_fff0_0000, 1'b1, 1'b0, 1'b1);
        bus(1'b1, 8'h40, 32'h0000_0010);
        mem(36'h0_0100_0000, 1'b0, 1'b0, 1'b1);
    endtask
    task t_io;
        hio(32'hffff_1234, 32'h0000_1234, 12'h023, 1'b1);
        hio(32'hffff_1034, 32'h0000_1034, 12'h103, 1'b0);
        bus(1'b1, 8'h48, 32'hffff_ffff);
        rchk(8'h48, 32'h0000_0006);
        bus(1'b1, 8'h48, 32'h0000_0000);
        hio(32'hffff_1234, 32'hffff_1234, 12'h123, 1'b0);
        pci_io_valid <= 1'b1;
        pci_io_addr <= 32'h0001_0000;
        repeat (2) @(posedge mclk);
        chk("pio_high", 32'h0, pci_io_to_host);
        pci_io_addr <= 32'h0000_ffff;
        repeat (2) @(posedge mclk);
        chk("pio_low", 32'h1, pci_io_to_host);
    endtask
    task t_burst;
        bus(1'b1, 8'h0d, 32'h0000_0003);
        burst_active <= 1'b1;
        repeat (24) @(posedge mclk);
        chk("stop_granted", 32'h0, burst_stop);
        burst_active <= 1'b0;
        repeat (2) @(posedge mclk);
        burst_active <= 1'b1;
        other_req <= 1'b1;
        n = 0;
        while (burst_stop !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n = n + 1;
        end
        chk("stop_in_time", 32'h1, n <= 16);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_top;
        t_io;
        t_burst;
        close_out;
    end
endmodule // testbench
